// *** core/flut_pkg.sv ***
package flut_pkg;
   // bus geometry
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam int TEMP_W = 11;
   // printed table offsets are register indices, byte address is index * 4
   localparam logic [9:0] IDX_LIMIT8 = 10'h05e;
   localparam logic [9:0] IDX_DUTY8 = 10'h05f;
   localparam logic [9:0] IDX_LIMIT9 = 10'h060;
   localparam logic [9:0] IDX_DUTY9 = 10'h061;
   localparam logic [11:0] ADDR_LIMIT8 = {IDX_LIMIT8, 2'b00};
   localparam logic [11:0] ADDR_DUTY8 = {IDX_DUTY8, 2'b00};
   localparam logic [11:0] ADDR_LIMIT9 = {IDX_LIMIT9, 2'b00};
   localparam logic [11:0] ADDR_DUTY9 = {IDX_DUTY9, 2'b00};
   localparam logic [11:0] ADDR_CFG = 12'h000;
   localparam logic [11:0] ADDR_OFFSET = 12'h004;
   localparam logic [11:0] ADDR_STATUS = 12'h008;
   // reset values
   localparam logic [7:0] RST_LIMIT = 8'h7f;
   localparam logic [7:0] RST_DUTY = 8'h3f;
   localparam logic [7:0] RST_CFG = 8'h00;
   localparam logic [7:0] RST_OFFSET = 8'h00;
   // field positions
   localparam int CFG_TEMP_HIRES = 0;
   localparam int CFG_DUTY_HIRES = 1;
   localparam int CFG_PWM_22K5 = 2;
   localparam int CFG_TBL_WR_EN = 5;
   localparam int LIMIT_TOP_BIT = 7;
   localparam int DUTY_EXT_LSB = 6;
   localparam int STAT_DUTY_LSB = 8;
   // mode bits carried together
   typedef struct packed {
      logic tbl_wr_en;
      logic pwm_22k5;
      logic duty_hires;
      logic temp_hires;
   } flut_cfg_t;
   // decoded bus request
   typedef struct packed {
      logic wr;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } flut_bus_t;
endpackage

// *** core/flut_entry.sv ***
`timescale 1ns/100ps
`default_nettype none
module flut_entry (
   // one table entry pair
   input wire logic [7:0] limit_byte,
   input wire logic [7:0] duty_byte,
   // modes and reading
   input wire flut_pkg::flut_cfg_t cfg,
   input wire logic [flut_pkg::TEMP_W-1:0] remote_temp,
   input wire logic [7:0] temp_offset,
   // result
   output logic exceed,
   output logic [7:0] duty_val
);
   logic [9:0] lim_hi;
   logic [8:0] lim_lo;
   logic exceed_hi;
   logic exceed_lo;
   logic ext_on;

   // limits are zero extended: the sign is taken as zero
   // offset widens the sum so limits past 127 degrees cannot wrap
   assign lim_hi = {2'b00, limit_byte[6:0], limit_byte[7]} + {1'b0, temp_offset, 1'b0};
   assign lim_lo = {2'b00, limit_byte[6:0]} + {1'b0, temp_offset};
   // half degree compare on nine reading bits
   assign exceed_hi = {1'b0, remote_temp[10:2]} > lim_hi;
   // whole degree compare on eight reading bits
   assign exceed_lo = {1'b0, remote_temp[10:3]} > lim_lo;
   assign exceed = cfg.temp_hires ? exceed_hi : exceed_lo;

   // extended bits only count at the 22.5 kHz setting
   assign ext_on = cfg.duty_hires & cfg.pwm_22k5;
   // full byte in high resolution at 22.5 kHz, six base bits otherwise
   assign duty_val = ext_on ? duty_byte : {2'b00, duty_byte[5:0]};
endmodule
`default_nettype wire

// *** core/flut_apb.sv ***
`timescale 1ns/100ps
`default_nettype none
module flut_apb (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // apb slave side
   input wire logic [flut_pkg::ADDR_W-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [flut_pkg::DATA_W-1:0] pwdata,
   output logic [flut_pkg::DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   // register file side
   input wire logic [flut_pkg::DATA_W-1:0] rd_value,
   input wire logic addr_hit,
   output flut_pkg::flut_bus_t bus
);
   logic setup;
   logic [flut_pkg::DATA_W-1:0] prdata_r;
   logic pslverr_r;

   // zero wait states: every access phase completes
   assign pready = 1'b1;
   assign setup = psel & ~penable;
   assign bus.wr = psel & penable & pwrite;
   assign bus.addr = paddr;
   assign bus.wdata = pwdata;
   assign prdata = prdata_r;
   assign pslverr = pslverr_r;

   // answer is captured in setup so data comes from flops in access
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         prdata_r <= '0;
         pslverr_r <= 1'b0;
      end else if (setup) begin
         prdata_r <= pwrite ? '0 : rd_value;
         pslverr_r <= ~addr_hit;
      end
   end
endmodule
`default_nettype wire

// *** core/flut_lut_slice.sv ***
// Behaviour
// - low temperature resolution keeps limit top bit zero, reads back zero.
// - high resolution limit is eight bits, half degrees, against nine reading bits.
// - low resolution limit is seven bits, whole degrees, against eight reading bits.
// - reading above a limit drives the fan duty from the paired duty entry.
// - limits are always non-negative; sign bit taken as zero.
// - table temperature offset is added to each limit in the compare.
// - low duty resolution keeps the two extended duty bits zero.
// - high duty resolution forms duty from extended and base bits.
// - extended duty bits act only with 22.5 kHz pwm selected.
// - low resolution duty uses the six base bits only.
`timescale 1ns/100ps
`default_nettype none
module flut_lut_slice (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // apb
   input wire logic [flut_pkg::ADDR_W-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [flut_pkg::DATA_W-1:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [flut_pkg::DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   // temperature in, fan duty out
   input wire logic [flut_pkg::TEMP_W-1:0] remote_temp,
   output logic [7:0] fan_duty,
   output logic fan_duty_vld
);
   flut_pkg::flut_bus_t bus;
   flut_pkg::flut_cfg_t cfg;
   logic [7:0] cfg_r;
   logic [7:0] cfg_nxt;
   logic [7:0] offset_r;
   logic [7:0] offset_nxt;
   logic [7:0] limit8_r;
   logic [7:0] limit8_nxt;
   logic [7:0] duty8_r;
   logic [7:0] duty8_nxt;
   logic [7:0] limit9_r;
   logic [7:0] limit9_nxt;
   logic [7:0] duty9_r;
   logic [7:0] duty9_nxt;
   logic [7:0] fan_duty_r;
   logic [7:0] fan_duty_nxt;
   logic fan_vld_r;
   logic fan_vld_nxt;
   logic lane0;
   logic tbl_wr;
   logic wr_cfg;
   logic wr_offset;
   logic wr_limit8;
   logic wr_duty8;
   logic wr_limit9;
   logic wr_duty9;
   logic hit_cfg;
   logic hit_offset;
   logic hit_status;
   logic hit_limit8;
   logic hit_duty8;
   logic hit_limit9;
   logic hit_duty9;
   logic addr_hit;
   logic [7:0] wbyte;
   logic [7:0] lim_mask;
   logic [7:0] duty_mask;
   logic [7:0] status_lo;
   logic [flut_pkg::DATA_W-1:0] rd_value;
   logic exceed8;
   logic exceed9;
   logic [7:0] duty8_val;
   logic [7:0] duty9_val;
   logic [7:0] limit8_rd;
   logic [7:0] duty8_rd;
   logic [7:0] limit9_rd;
   logic [7:0] duty9_rd;
   logic rd_acc;

   // bus slave
   flut_apb u_apb (
      .clk(clk),
      .rst(rst),
      .paddr(paddr),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .pwdata(pwdata),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .rd_value(rd_value),
      .addr_hit(addr_hit),
      .bus(bus)
   );

   // mode bits out of the config register
   assign cfg.tbl_wr_en = cfg_r[flut_pkg::CFG_TBL_WR_EN];
   assign cfg.pwm_22k5 = cfg_r[flut_pkg::CFG_PWM_22K5];
   assign cfg.duty_hires = cfg_r[flut_pkg::CFG_DUTY_HIRES];
   assign cfg.temp_hires = cfg_r[flut_pkg::CFG_TEMP_HIRES];

   // address decode
   assign hit_cfg = bus.addr == flut_pkg::ADDR_CFG;
   assign hit_offset = bus.addr == flut_pkg::ADDR_OFFSET;
   assign hit_status = bus.addr == flut_pkg::ADDR_STATUS;
   assign hit_limit8 = bus.addr == flut_pkg::ADDR_LIMIT8;
   assign hit_duty8 = bus.addr == flut_pkg::ADDR_DUTY8;
   assign hit_limit9 = bus.addr == flut_pkg::ADDR_LIMIT9;
   assign hit_duty9 = bus.addr == flut_pkg::ADDR_DUTY9;
   assign addr_hit = hit_cfg | hit_offset | hit_status | hit_limit8 | hit_duty8
                     | hit_limit9 | hit_duty9;

   // write strobes; only byte lane 0 carries data
   assign lane0 = bus.wr & pstrb[0];
   assign wbyte = bus.wdata[7:0];
   // table writes are dropped silently while the enable is clear
   assign tbl_wr = lane0 & cfg.tbl_wr_en;
   assign wr_cfg = lane0 & hit_cfg;
   assign wr_offset = lane0 & hit_offset;
   assign wr_limit8 = tbl_wr & hit_limit8;
   assign wr_duty8 = tbl_wr & hit_duty8;
   assign wr_limit9 = tbl_wr & hit_limit9;
   assign wr_duty9 = tbl_wr & hit_duty9;

   // masks clear the top limit bit and the extended duty bits in low res
   assign lim_mask = {cfg.temp_hires, 7'h7f};
   assign duty_mask = {{2{cfg.duty_hires}}, 6'h3f};

   // next values: the mask applies every cycle, so a mode switch clears too
   assign cfg_nxt = wr_cfg ? wbyte : cfg_r;
   assign offset_nxt = wr_offset ? wbyte : offset_r;
   assign limit8_nxt = (wr_limit8 ? wbyte : limit8_r) & lim_mask;
   assign limit9_nxt = (wr_limit9 ? wbyte : limit9_r) & lim_mask;
   assign duty8_nxt = (wr_duty8 ? wbyte : duty8_r) & duty_mask;
   assign duty9_nxt = (wr_duty9 ? wbyte : duty9_r) & duty_mask;

   // mask on the read path too, so a read right after a mode switch is already clean
   assign limit8_rd = limit8_r & lim_mask;
   assign duty8_rd = duty8_r & duty_mask;
   assign limit9_rd = limit9_r & lim_mask;
   assign duty9_rd = duty9_r & duty_mask;

   // read mux; entries stay readable whatever the enable
   assign status_lo = {6'h00, exceed9, exceed8};
   assign rd_value = hit_cfg ? {24'h000000, cfg_r} :
                     hit_offset ? {24'h000000, offset_r} :
                     hit_status ? {16'h0000, fan_duty_r, status_lo} :
                     hit_limit8 ? {24'h000000, limit8_rd} :
                     hit_duty8 ? {24'h000000, duty8_rd} :
                     hit_limit9 ? {24'h000000, limit9_rd} :
                     hit_duty9 ? {24'h000000, duty9_rd} : 32'h00000000;

   // register file
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cfg_r <= flut_pkg::RST_CFG;
         offset_r <= flut_pkg::RST_OFFSET;
         limit8_r <= flut_pkg::RST_LIMIT;
         duty8_r <= flut_pkg::RST_DUTY;
         limit9_r <= flut_pkg::RST_LIMIT;
         duty9_r <= flut_pkg::RST_DUTY;
      end else begin
         cfg_r <= cfg_nxt;
         offset_r <= offset_nxt;
         limit8_r <= limit8_nxt;
         duty8_r <= duty8_nxt;
         limit9_r <= limit9_nxt;
         duty9_r <= duty9_nxt;
      end
   end

   // compare and duty shaping, one instance per entry pair
   flut_entry u_entry8 (
      .limit_byte(limit8_r),
      .duty_byte(duty8_r),
      .cfg(cfg),
      .remote_temp(remote_temp),
      .temp_offset(offset_r),
      .exceed(exceed8),
      .duty_val(duty8_val)
   );
   flut_entry u_entry9 (
      .limit_byte(limit9_r),
      .duty_byte(duty9_r),
      .cfg(cfg),
      .remote_temp(remote_temp),
      .temp_offset(offset_r),
      .exceed(exceed9),
      .duty_val(duty9_val)
   );

   // the higher entry wins; below both limits the rest of the table owns the fan
   assign fan_duty_nxt = exceed9 ? duty9_val : exceed8 ? duty8_val : 8'h00;
   assign fan_vld_nxt = exceed9 | exceed8;
   assign fan_duty = fan_duty_r;
   assign fan_duty_vld = fan_vld_r;

   // registered fan output, one cycle behind the reading
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         fan_duty_r <= 8'h00;
         fan_vld_r <= 1'b0;
      end else begin
         fan_duty_r <= fan_duty_nxt;
         fan_vld_r <= fan_vld_nxt;
      end
   end

   // checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   // read access phase, shared by the read-back checks
   assign rd_acc = psel & penable & ~pwrite;

   a_limit_top_zero: assert property (
      !cfg.temp_hires |=> !limit8_r[flut_pkg::LIMIT_TOP_BIT] && !limit9_r[7])
      else $error("limit top bit set in low resolution");

   a_hires_compare: assert property (
      cfg.temp_hires && offset_r == 8'h00 && exceed8
      |-> remote_temp[10:2] > {1'b0, limit8_r[6:0], limit8_r[7]})
      else $error("high resolution compare wrong");

   a_lores_compare: assert property (
      !cfg.temp_hires && offset_r == 8'h00
      |-> exceed8 == (remote_temp[10:3] > {1'b0, limit8_r[6:0]}))
      else $error("low resolution compare wrong");

   a_duty_follows: assert property (
      exceed9 |=> fan_duty == $past(duty9_val) && fan_duty_vld)
      else $error("fan duty not from entry nine");

   a_duty_eight: assert property (
      exceed8 && !exceed9 |=> fan_duty == $past(duty8_val))
      else $error("fan duty not from entry eight");

   a_zero_never: assert property (
      remote_temp == 11'h000 |-> !exceed8 && !exceed9)
      else $error("limit treated as negative");

   a_offset_applied: assert property (
      !cfg.temp_hires && exceed9 |-> remote_temp[10:3] > offset_r)
      else $error("offset not applied");

   a_ext_low_zero: assert property (
      !cfg.duty_hires |=> duty8_r[7:6] == 2'b00 && duty9_r[7:6] == 2'b00)
      else $error("extended duty bits set in low resolution");

   a_ext_duty_full: assert property (
      cfg.duty_hires && cfg.pwm_22k5 |-> duty8_val == duty8_r)
      else $error("extended duty bits not used");

   a_ext_gated: assert property (
      !cfg.pwm_22k5 |-> duty8_val[7:6] == 2'b00 && duty9_val[7:6] == 2'b00)
      else $error("extended bits active off 22.5 kHz");

   a_base_only: assert property (
      !cfg.duty_hires |-> duty9_val == {2'b00, duty9_r[5:0]})
      else $error("low resolution duty wrong");

   a_write_locked: assert property (
      bus.wr && hit_limit8 && !cfg.tbl_wr_en |=> $stable(limit8_r))
      else $error("table written while locked");

   a_write_taken: assert property (
      lane0 && hit_duty8 && cfg.tbl_wr_en && cfg.duty_hires && !wr_cfg
      |=> duty8_r == $past(wbyte))
      else $error("enabled table write lost");

   // write paths: locked, strobed and enabled writes
   a_locked_all: assert property (
      bus.wr && !cfg.tbl_wr_en
      |=> $stable(limit8_r) && $stable(duty8_r) && $stable(limit9_r) && $stable(duty9_r))
      else $error("table entry changed while locked");

   a_limit9_taken: assert property (
      wr_limit9 && cfg.temp_hires |=> limit9_r == $past(wbyte))
      else $error("enabled limit write lost");

   a_cfg_taken: assert property (
      wr_cfg |=> cfg_r == $past(wbyte))
      else $error("config write lost");

   a_offset_taken: assert property (
      wr_offset |=> offset_r == $past(wbyte))
      else $error("offset write lost");

   a_lane_gate: assert property (
      bus.wr && !pstrb[0] |=> $stable(cfg_r) && $stable(offset_r) && $stable(limit8_r))
      else $error("write taken with low byte strobe off");

   a_fan_idle: assert property (
      !exceed8 && !exceed9 |=> fan_duty == 8'h00 && !fan_duty_vld)
      else $error("fan duty driven below both limits");

   a_hires_nine: assert property (
      cfg.temp_hires && offset_r == 8'h00
      |-> exceed9 == (remote_temp[10:2] > {1'b0, limit9_r[6:0], limit9_r[7]}))
      else $error("high resolution compare wrong on entry nine");

   a_lores_offset: assert property (
      !cfg.temp_hires
      |-> exceed9 == ({1'b0, remote_temp[10:3]} > ({2'b00, limit9_r[6:0]} + {1'b0, offset_r})))
      else $error("low resolution offset compare wrong");

   a_duty9_full: assert property (
      cfg.duty_hires && cfg.pwm_22k5 |-> duty9_val == duty9_r)
      else $error("extended duty bits not used on entry nine");

   a_read_top_zero: assert property (
      rd_acc && (hit_limit8 || hit_limit9) && !cfg.temp_hires |-> !prdata[7])
      else $error("limit top bit read back in low resolution");

   a_read_ext_zero: assert property (
      rd_acc && (hit_duty8 || hit_duty9) && !cfg.duty_hires |-> prdata[7:6] == 2'b00)
      else $error("extended duty bits read back in low resolution");

   a_read_upper: assert property (
      rd_acc |-> prdata[31:16] == 16'h0000)
      else $error("upper read data bits set");

   a_status_read: assert property (
      rd_acc && hit_status |-> prdata[1:0] == {$past(exceed9), $past(exceed8)})
      else $error("status read does not match the compare");

   a_unmapped_err: assert property (
      psel && penable && !addr_hit |-> pslverr && prdata == 32'h00000000)
      else $error("unmapped access not refused");

   a_mapped_ok: assert property (
      psel && penable && addr_hit |-> !pslverr)
      else $error("mapped access answered with an error");

   c_hires_exceed: cover property (cfg.temp_hires && exceed8 ##1 fan_duty_vld);
   c_both_exceed: cover property (exceed8 && exceed9);
   c_locked_write: cover property (bus.wr && hit_duty9 && !cfg.tbl_wr_en);
   c_ext_duty: cover property (cfg.duty_hires && cfg.pwm_22k5 && exceed9);
   c_offset_exceed: cover property (offset_r != 8'h00 && exceed9);
endmodule
`default_nettype wire

// *** dv/tb_flut_lut_slice.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb_flut_lut_slice;
   // bench clock, reset and design pins
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [11:0] paddr = 12'h000;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0;
   logic [3:0] pstrb = 4'hf;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [10:0] remote_temp = 11'h000;
   logic [7:0] fan_duty;
   logic fan_duty_vld;
   int fails = 0;
   int cmp_count = 0;
   logic [31:0] rd_v;
   logic err_v;

   // 25 MHz clock
   always #20 clk = ~clk;

   flut_lut_slice u_flut_lut_slice (
      .clk(clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .remote_temp(remote_temp),
      .fan_duty(fan_duty), .fan_duty_vld(fan_duty_vld)
   );

   // single place where the run ends
   task automatic conclude;
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // one compare for every kind of result
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask

   // one apb transfer; the wait on pready is bounded so a dead slave cannot hang us
   task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         fails++;
         $display("FAIL pready expected 1 seen %b", pready);
         conclude();
      end
      rd_v = prdata;
      err_v = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // read a register and judge data and error response
   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 8'h00);
      chk("prdata", exp, rd_v);
      chk("pslverr", 32'h0, {31'h0, err_v});
   endtask

   // fan output lags the reading by one registered stage
   task automatic fan(input logic [10:0] t, input logic v, input logic [7:0] d);
      @(posedge clk);
      remote_temp <= t;
      repeat (2) @(posedge clk);
      #1;
      chk("fan_duty_vld", {31'h0, v}, {31'h0, fan_duty_vld});
      chk("fan_duty", {24'h0, d}, {24'h0, fan_duty});
   endtask

   // reset values, plus an unmapped read that must be refused
   task automatic t_reset;
      rd(flut_pkg::ADDR_LIMIT8, 32'h7f);
      rd(flut_pkg::ADDR_DUTY8, 32'h3f);
      rd(flut_pkg::ADDR_LIMIT9, 32'h7f);
      rd(flut_pkg::ADDR_DUTY9, 32'h3f);
      apb(1'b0, 12'hff0, 8'h00);
      chk("unmapped pslverr", 32'h1, {31'h0, err_v});
      chk("unmapped prdata", 32'h0, rd_v);
   endtask

   // table writes ignored while locked, and with the low byte strobe off
   task automatic t_lock;
      apb(1'b1, flut_pkg::ADDR_LIMIT8, 8'h10);
      chk("locked pslverr", 32'h0, {31'h0, err_v});
      rd(flut_pkg::ADDR_LIMIT8, 32'h7f);
      apb(1'b1, flut_pkg::ADDR_CFG, 8'h20);
      pstrb <= 4'he;
      apb(1'b1, flut_pkg::ADDR_LIMIT8, 8'h10);
      pstrb <= 4'hf;
      rd(flut_pkg::ADDR_LIMIT8, 32'h7f);
   endtask

   // high resolution: limit8 = 20.5 degC, i.e. 41 half degrees
   task automatic t_hires;
      apb(1'b1, flut_pkg::ADDR_CFG, 8'h27);
      apb(1'b1, flut_pkg::ADDR_LIMIT8, 8'h94);
      apb(1'b1, flut_pkg::ADDR_DUTY8, 8'hc5);
      apb(1'b1, flut_pkg::ADDR_LIMIT9, 8'hff);
      rd(flut_pkg::ADDR_LIMIT8, 32'h94);
      rd(flut_pkg::ADDR_DUTY8, 32'hc5);
      fan(11'd167, 1'b0, 8'h00);
      fan(11'd168, 1'b1, 8'hc5);
      fan(11'h7ff, 1'b1, 8'h3f);
      apb(1'b1, flut_pkg::ADDR_CFG, 8'h23);
      fan(11'd168, 1'b1, 8'h05);
      apb(1'b1, flut_pkg::ADDR_CFG, 8'h25);
      rd(flut_pkg::ADDR_DUTY8, 32'h05);
      fan(11'd168, 1'b1, 8'h05);
   endtask

   // low resolution, then offset and entry nine priority
   task automatic t_lowres;
      apb(1'b1, flut_pkg::ADDR_CFG, 8'h20);
      rd(flut_pkg::ADDR_LIMIT8, 32'h14);
      fan(11'd167, 1'b0, 8'h00);
      fan(11'd168, 1'b1, 8'h05);
      apb(1'b1, flut_pkg::ADDR_OFFSET, 8'h03);
      fan(11'd191, 1'b0, 8'h00);
      fan(11'd192, 1'b1, 8'h05);
      apb(1'b1, flut_pkg::ADDR_LIMIT9, 8'h1e);
      apb(1'b1, flut_pkg::ADDR_DUTY9, 8'h0a);
      fan(11'd271, 1'b1, 8'h05);
      fan(11'd272, 1'b1, 8'h0a);
      rd(flut_pkg::ADDR_STATUS, 32'h00000a03);
   endtask

   // main sequence
   initial begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_lock();
      t_hires();
      t_lowres();
      conclude();
   end
endmodule
`default_nettype wire
